/* mid_consts.svh */
// constants of the instruction decode and execute block
`ifndef MID_CONSTS_SVH
`define MID_CONSTS_SVH
// ==============================
// register offsets (byte address)
`define MID_OFF_INSTR   8'h00
`define MID_OFF_ACCUM   8'h04
`define MID_OFF_FILEVAL 8'h08
`define MID_OFF_STATUS  8'h0C
`define MID_OFF_CTRL    8'h10
`define MID_OFF_IOADDR  8'h14
`define MID_OFF_RESULT  8'h18
`define MID_OFF_TARGET  8'h1C
// ==============================
// status field positions
`define MID_ST_C  0
`define MID_ST_DC 1
`define MID_ST_Z  2
`define MID_ST_TO 3
`define MID_ST_PWRDN 4
// control field positions
`define MID_CT_PTMR 0
`define MID_CT_WAKE 1
// ==============================
// reset values and fixed addresses
`define MID_RST_IOADDR 7'h06
`define MID_TZERO_ADDR 7'h01
// ==============================
// timing: index of the last oscillator period in an instruction cycle
`define MID_QPER_LAST  2'h3
// axi responses
`define MID_RESP_OKAY   2'h0
`define MID_RESP_SLVERR 2'h2
`endif

/* mid_pkg.sv */
// types of the instruction decode and execute block
package mid_pkg;
  // run state of the cycle sequencer
  typedef enum logic [0:0] {
    MID_IDLE = 1'b0,
    MID_RUN  = 1'b1
  } mid_state_e;

  // class of the last decoded word
  typedef enum logic [3:0] {
    MID_K_NONE   = 4'h0,
    MID_K_BYTE   = 4'h1,
    MID_K_BIT    = 4'h2,
    MID_K_LIT    = 4'h3,
    MID_K_JUMP   = 4'h4,
    MID_K_CALL   = 4'h5,
    MID_K_RET    = 4'h6,
    MID_K_RETLIT = 4'h7,
    MID_K_RETIRQ = 4'h8,
    MID_K_SLEEP  = 4'h9,
    MID_K_WDT    = 4'hA,
    MID_K_NOP    = 4'hB
  } mid_kind_e;

  // whole state of the block
  typedef struct packed {
    mid_state_e  st;
    logic [1:0]  phase;
    logic        second;
    logic        awready;
    logic        aw_ok;
    logic [7:0]  aw_a;
    logic        wready;
    logic        w_ok;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [13:0] instr;
    logic [7:0]  acc;
    logic [7:0]  fval;
    logic        c;
    logic        dc;
    logic        z;
    logic        to;
    logic        pwrdn;
    logic        ptmr;
    logic [6:0]  ioaddr;
    logic [7:0]  res;
    logic        dest_f;
    logic [6:0]  faddr;
    logic        skip;
    logic        two;
    logic [10:0] target;
    mid_kind_e   kind;
    logic        busy;
    logic        standby;
    logic        wdtclr;
    logic        psclr;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
  } mid_state_s;
endpackage

/* mid_decoder.sv */
// instruction decoder and execute unit with an axi4-lite register port
`timescale 1ns/1ps
`include "mid_consts.svh"
// What this block does
// - file address is low seven bits
// - destination bit picks accumulator or file
// - prefix 00 marks byte-oriented words
// - three-bit field picks bit zero to seven
// - don't-care bits never change decoding
// - 0100: or accumulator with file, zero only
// - 0110: xor accumulator with file, zero only
// - 1101/1100 rotate through carry, carry only
// - 1011/1111 dec/inc, skip on zero, no flags
// - bit test skips when bit clear
// - bit test skips when bit set
// - literal 1000 ors into accumulator, zero
// - literal 1010 xors into accumulator, zero
// - literal 110x: literal minus accumulator, flags
// - literal 01xx returns with literal, two cycles
// - word 0x008 returns, two cycles, no flags
// - word 0x009 returns from interrupt, two cycles
// - word 0x063 enters standby, sets time-out flag, clears power-down flag
// - word 0x064 clears watchdog, sets power flags
// - port self-modify reads pin levels
// - timer-zero write clears assigned prescaler
// - program counter change or true skip adds nop
// - literals eight bits, jump targets eleven
// - one instruction cycle is four periods
module mid_decoder (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_pins,
  output logic             busy,
  output logic             standby,
  output logic             watchdog_clear,
  output logic             prescaler_clear
);
  // ==============================
  // state
  mid_pkg::mid_state_s s_reg;   // registered state
  mid_pkg::mid_state_s s_next;  // next state

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] o,
                                             input logic [31:0] d,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==============================
  // next-state logic
  always_comb begin
    logic [13:0] ins;     // word being decoded
    logic [6:0]  fa;      // file address field
    logic        dsel;    // destination select
    logic [2:0]  bsel;    // bit select
    logic [7:0]  lit;     // eight-bit literal
    logic [7:0]  src;     // file operand value
    logic [7:0]  opb;     // second adder operand
    logic [8:0]  sum_a;   // add result
    logic [8:0]  sum_s;   // subtract result
    logic [4:0]  hs_a;    // add low nibble
    logic [4:0]  hs_s;    // subtract low nibble
    logic [7:0]  alu;     // operation result
    logic        wr;      // result is stored
    logic        upd_z;   // zero flag updated
    logic        pcmod;   // program counter altered
    logic        tst;     // skip condition
    logic [31:0] wm;      // merged write word
    logic        exec;    // instruction write taken
    logic        wok;     // write address mapped
    ins   = 14'h0000;
    fa    = 7'h00;
    dsel  = 1'b0;
    bsel  = 3'h0;
    lit   = 8'h00;
    src   = 8'h00;
    opb   = 8'h00;
    sum_a = 9'h000;
    sum_s = 9'h000;
    hs_a  = 5'h00;
    hs_s  = 5'h00;
    alu   = 8'h00;
    wr    = 1'b0;
    upd_z = 1'b0;
    pcmod = 1'b0;
    tst   = 1'b0;
    wm    = 32'h0000_0000;
    exec  = 1'b0;
    wok   = 1'b1;
    s_next = s_reg;
    s_next.sync1  = port_pins;
    s_next.sync2  = s_reg.sync1;
    s_next.wdtclr = 1'b0;
    s_next.psclr  = 1'b0;

    // instruction cycle sequencer: four periods per cycle
    if (s_reg.st == mid_pkg::MID_RUN) begin
      s_next.phase = s_reg.phase + 2'h1;
      if (s_reg.phase == `MID_QPER_LAST) begin
        if (s_reg.two && !s_reg.second) begin
          s_next.second = 1'b1;
        end else begin
          s_next.st     = mid_pkg::MID_IDLE;
          s_next.second = 1'b0;
        end
      end
    end

    // write address channel
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_ok = 1'b1;
      s_next.aw_a  = s_axi_awaddr;
    end
    // write data channel
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_ok = 1'b1;
      s_next.w_d  = s_axi_wdata;
      s_next.w_s  = s_axi_wstrb;
    end
    // response retired
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // register write once both halves are held
    if (s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid) begin
      s_next.aw_ok  = 1'b0;
      s_next.w_ok   = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = `MID_RESP_OKAY;
      case (s_reg.aw_a)
        `MID_OFF_INSTR: begin
          // refused while running or in standby
          if (s_reg.st == mid_pkg::MID_IDLE && !s_reg.standby) begin
            wm   = lane_merge({18'h00000, s_reg.instr}, s_reg.w_d, s_reg.w_s);
            exec = 1'b1;
          end else begin
            s_next.bresp = `MID_RESP_SLVERR;
          end
        end
        `MID_OFF_ACCUM: begin
          wm = lane_merge({24'h000000, s_reg.acc}, s_reg.w_d, s_reg.w_s);
          s_next.acc = wm[7:0];
        end
        `MID_OFF_FILEVAL: begin
          wm = lane_merge({24'h000000, s_reg.fval}, s_reg.w_d, s_reg.w_s);
          s_next.fval = wm[7:0];
        end
        `MID_OFF_STATUS: begin
          // only arithmetic flags are writable
          if (s_reg.w_s[0]) begin
            s_next.c  = s_reg.w_d[`MID_ST_C];
            s_next.dc = s_reg.w_d[`MID_ST_DC];
            s_next.z  = s_reg.w_d[`MID_ST_Z];
          end
        end
        `MID_OFF_CTRL: begin
          if (s_reg.w_s[0]) begin
            s_next.ptmr = s_reg.w_d[`MID_CT_PTMR];
            if (s_reg.w_d[`MID_CT_WAKE]) begin
              s_next.standby = 1'b0;
            end
          end
        end
        `MID_OFF_IOADDR: begin
          if (s_reg.w_s[0]) begin
            s_next.ioaddr = s_reg.w_d[6:0];
          end
        end
        `MID_OFF_RESULT, `MID_OFF_TARGET: begin
          wok = 1'b1;  // read-only, write ignored
        end
        default: begin
          wok = 1'b0;
        end
      endcase
      if (!wok) begin
        s_next.bresp = `MID_RESP_SLVERR;
      end
    end

    // decode and execute a taken word
    if (exec) begin
      ins  = wm[13:0];
      fa   = ins[6:0];
      dsel = ins[7];
      bsel = ins[9:7];
      lit  = ins[7:0];
      src  = (fa == s_reg.ioaddr) ? s_reg.sync2 : s_reg.fval;
      opb  = (ins[13:12] == 2'b11) ? lit : src;
      sum_a = {1'b0, opb} + {1'b0, s_reg.acc};
      hs_a  = {1'b0, opb[3:0]} + {1'b0, s_reg.acc[3:0]};
      sum_s = {1'b0, opb} + {1'b0, ~s_reg.acc} + 9'h001;
      hs_s  = {1'b0, opb[3:0]} + {1'b0, ~s_reg.acc[3:0]} + 5'h01;
      s_next.kind = mid_pkg::MID_K_NONE;
      casez (ins)
        // byte-oriented file operations
        14'b00_????_????_????: begin
          s_next.kind = mid_pkg::MID_K_BYTE;
          wr = 1'b1;
          case (ins[11:8])
            4'b0000: begin
              alu = s_reg.acc;
              wr  = dsel;
              if (!dsel) begin
                // control words: x bits ignored
                casez (ins[7:0])
                  8'b0000_1000: begin
                    s_next.kind = mid_pkg::MID_K_RET;
                    pcmod = 1'b1;
                  end
                  8'b0000_1001: begin
                    s_next.kind = mid_pkg::MID_K_RETIRQ;
                    pcmod = 1'b1;
                  end
                  8'b0110_0011: begin
                    s_next.kind    = mid_pkg::MID_K_SLEEP;
                    s_next.standby = 1'b1;
                    s_next.to      = 1'b1;
                    s_next.pwrdn   = 1'b0;
                  end
                  8'b0110_0100: begin
                    s_next.kind   = mid_pkg::MID_K_WDT;
                    s_next.wdtclr = 1'b1;
                    s_next.to     = 1'b1;
                    s_next.pwrdn  = 1'b1;
                  end
                  default: begin
                    s_next.kind = mid_pkg::MID_K_NOP;
                  end
                endcase
              end
            end
            4'b0001: begin
              alu   = 8'h00;
              upd_z = 1'b1;
            end
            4'b0010: begin
              alu    = sum_s[7:0];
              s_next.c  = sum_s[8];
              s_next.dc = hs_s[4];
              upd_z  = 1'b1;
            end
            4'b0011: begin
              alu   = src - 8'h01;
              upd_z = 1'b1;
            end
            4'b0100: begin
              alu   = s_reg.acc | src;
              upd_z = 1'b1;
            end
            4'b0101: begin
              alu   = s_reg.acc & src;
              upd_z = 1'b1;
            end
            4'b0110: begin
              alu   = s_reg.acc ^ src;
              upd_z = 1'b1;
            end
            4'b0111: begin
              alu    = sum_a[7:0];
              s_next.c  = sum_a[8];
              s_next.dc = hs_a[4];
              upd_z  = 1'b1;
            end
            4'b1000: begin
              alu   = src;
              upd_z = 1'b1;
            end
            4'b1001: begin
              alu   = ~src;
              upd_z = 1'b1;
            end
            4'b1010: begin
              alu   = src + 8'h01;
              upd_z = 1'b1;
            end
            4'b1011, 4'b1111: begin
              alu = ins[10] ? src + 8'h01 : src - 8'h01;
              tst = (alu == 8'h00);
            end
            4'b1100: begin
              alu      = {s_reg.c, src[7:1]};
              s_next.c = src[0];
            end
            4'b1101: begin
              alu      = {src[6:0], s_reg.c};
              s_next.c = src[7];
            end
            default: begin
              alu = {src[3:0], src[7:4]};
            end
          endcase
          if (ins[11:8] == 4'b0001 && !dsel) begin
            wr = 1'b0;
            s_next.acc = 8'h00;
          end
          if (upd_z) begin
            s_next.z = (alu == 8'h00);
          end
        end
        // bit-oriented file operations
        14'b01_????_????_????: begin
          s_next.kind = mid_pkg::MID_K_BIT;
          alu  = src;
          dsel = 1'b1;
          case (ins[11:10])
            2'b00: begin
              alu[bsel] = 1'b0;
              wr = 1'b1;
            end
            2'b01: begin
              alu[bsel] = 1'b1;
              wr = 1'b1;
            end
            2'b10: begin
              tst = !src[bsel];
            end
            default: begin
              tst = src[bsel];
            end
          endcase
        end
        // jumps and calls take an eleven-bit target
        14'b10_????_????_????: begin
          s_next.kind   = ins[11] ? mid_pkg::MID_K_JUMP : mid_pkg::MID_K_CALL;
          s_next.target = ins[10:0];
          pcmod = 1'b1;
        end
        // literal operations
        default: begin
          s_next.kind = mid_pkg::MID_K_LIT;
          casez (ins[11:8])
            4'b00??: begin
              s_next.acc = lit;
            end
            4'b01??: begin
              s_next.kind = mid_pkg::MID_K_RETLIT;
              s_next.acc  = lit;
              pcmod = 1'b1;
            end
            4'b1000: begin
              s_next.acc = lit | s_reg.acc;
              s_next.z   = ((lit | s_reg.acc) == 8'h00);
            end
            4'b1001: begin
              s_next.acc = lit & s_reg.acc;
              s_next.z   = ((lit & s_reg.acc) == 8'h00);
            end
            4'b1010: begin
              s_next.acc = lit ^ s_reg.acc;
              s_next.z   = ((lit ^ s_reg.acc) == 8'h00);
            end
            4'b110?: begin
              s_next.acc = sum_s[7:0];
              s_next.c   = sum_s[8];
              s_next.dc  = hs_s[4];
              s_next.z   = (sum_s[7:0] == 8'h00);
            end
            default: begin
              s_next.acc = sum_a[7:0];
              s_next.c   = sum_a[8];
              s_next.dc  = hs_a[4];
              s_next.z   = (sum_a[7:0] == 8'h00);
            end
          endcase
          alu = s_next.acc;
        end
      endcase
      // route the result by destination select
      if (wr && dsel) begin
        s_next.fval = alu;
        s_next.psclr = (fa == `MID_TZERO_ADDR) && s_reg.ptmr;
      end else if (wr) begin
        s_next.acc = alu;
      end
      s_next.instr  = ins;
      s_next.res    = alu;
      s_next.dest_f = wr && dsel;
      s_next.faddr  = fa;
      s_next.skip   = tst;
      s_next.two    = pcmod || tst;
      s_next.st     = mid_pkg::MID_RUN;
      s_next.phase  = 2'h0;
      s_next.second = 1'b0;
    end

    // read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = `MID_RESP_OKAY;
      case (s_axi_araddr)
        `MID_OFF_INSTR:   s_next.rdata = {18'h00000, s_reg.instr};
        `MID_OFF_ACCUM:   s_next.rdata = {24'h000000, s_reg.acc};
        `MID_OFF_FILEVAL: s_next.rdata = {24'h000000, s_reg.fval};
        `MID_OFF_STATUS:  s_next.rdata = {27'h0000000, s_reg.pwrdn, s_reg.to, s_reg.z, s_reg.dc, s_reg.c};
        `MID_OFF_CTRL:    s_next.rdata = {31'h00000000, s_reg.ptmr};
        `MID_OFF_IOADDR:  s_next.rdata = {25'h0000000, s_reg.ioaddr};
        `MID_OFF_RESULT:  s_next.rdata = {8'h00, s_reg.kind, s_reg.standby, s_reg.busy, s_reg.two,
                                          s_reg.skip, s_reg.faddr, s_reg.dest_f, s_reg.res};
        `MID_OFF_TARGET:  s_next.rdata = {21'h000000, s_reg.target};
        default: begin
          s_next.rdata = 32'h0000_0000;
          s_next.rresp = `MID_RESP_SLVERR;
        end
      endcase
    end

    // registered readies and status outputs
    s_next.awready = !s_next.aw_ok && !s_next.bvalid;
    s_next.wready  = !s_next.w_ok && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
    s_next.busy    = (s_next.st == mid_pkg::MID_RUN);
  end

  // ==============================
  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg        <= '0;
      s_reg.st     <= mid_pkg::MID_IDLE;
      s_reg.kind   <= mid_pkg::MID_K_NONE;
      s_reg.ioaddr <= `MID_RST_IOADDR;
      s_reg.to     <= 1'b1;
      s_reg.pwrdn  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==============================
  // outputs straight from the state register
  assign s_axi_awready   = s_reg.awready;
  assign s_axi_wready    = s_reg.wready;
  assign s_axi_bvalid    = s_reg.bvalid;
  assign s_axi_bresp     = s_reg.bresp;
  assign s_axi_arready   = s_reg.arready;
  assign s_axi_rvalid    = s_reg.rvalid;
  assign s_axi_rdata     = s_reg.rdata;
  assign s_axi_rresp     = s_reg.rresp;
  assign busy            = s_reg.busy;
  assign standby         = s_reg.standby;
  assign watchdog_clear  = s_reg.wdtclr;
  assign prescaler_clear = s_reg.psclr;
endmodule

/* mid_decoder_chk.sv */
// port checks for the instruction decoder
`timescale 1ns/1ps
module mid_decoder_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        busy,
  input wire logic        standby,
  input wire logic        watchdog_clear,
  input wire logic        prescaler_clear
);
  // ==============================
  // one clock domain for all checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==============================
  // instruction timing
  AST_BUSY_LEN:
    assert property ($rose(busy) |-> busy[*4] ##1 (!busy or (busy[*4] ##1 !busy)))
    else $error("busy not four or eight clocks");
  AST_BUSY_ON_RESP:
    assert property ($rose(busy) |-> $rose(s_axi_bvalid) && s_axi_bresp == 2'h0)
    else $error("execution without okay response");
  AST_WDT_PULSE:
    assert property (watchdog_clear |-> $rose(busy) ##1 (!watchdog_clear && busy) ##3 !busy)
    else $error("watchdog clear pulse or length wrong");
  AST_SLEEP_ONE:
    assert property ($rose(standby) |-> $rose(busy) ##4 !busy)
    else $error("standby word not one cycle");
  AST_SLEEP_HOLD:
    assert property (standby && $past(standby) |-> !$rose(busy))
    else $error("instruction ran in standby");
  AST_PSC_PULSE:
    assert property (prescaler_clear |-> $rose(busy) ##1 !prescaler_clear)
    else $error("prescaler clear pulse wrong");
  // ==============================
  // response handshakes
  AST_B_RETIRE:
    assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped without ready");
  AST_R_RETIRE:
    assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped without ready");
endmodule

bind mid_decoder mid_decoder_chk chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .busy(busy), .standby(standby), .watchdog_clear(watchdog_clear), .prescaler_clear(prescaler_clear));

/* mid_prog_mem.sv */
// program memory model holding the test instruction words
`timescale 1ns/1ps
module mid_prog_mem (
  input wire logic [4:0]  addr,
  output logic     [13:0] word
);
  // ==============================
  // word table, don't-care bits set to one on purpose
  always_comb begin
    case (addr)
      5'h00: word = 14'h04A0;
      5'h01: word = 14'h067F;
      5'h02: word = 14'h0DA0;
      5'h03: word = 14'h0CA0;
      5'h04: word = 14'h0BA0;
      5'h05: word = 14'h0F20;
      5'h06: word = 14'h1BA0;
      5'h07: word = 14'h1C20;
      5'h08: word = 14'h380F;
      5'h09: word = 14'h3AFF;
      5'h0A: word = 14'h3D05;
      5'h0B: word = 14'h373C;
      5'h0C: word = 14'h0008;
      5'h0D: word = 14'h0009;
      5'h0E: word = 14'h0064;
      5'h0F: word = 14'h0686;
      5'h10: word = 14'h2FFF;
      5'h11: word = 14'h0481;
      5'h12: word = 14'h0063;
      default: word = 14'h0000; // plain no-operation
    endcase
  end
endmodule

/* mid_decoder_tb.sv */
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module mid_decoder_tb;
  // ==============================
  // bench signals
  logic        aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic        awready, wready, arready, busy, standby, wdt, psc;
  logic [7:0]  awaddr, araddr, pins;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] d;
  logic [4:0]  pm_addr;
  logic [13:0] pm_word;
  int          mismatches, cmp_count, wdt_n, psc_n;
  // ==============================
  // design and program memory
  mid_decoder dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .port_pins(pins), .busy(busy), .standby(standby),
    .watchdog_clear(wdt), .prescaler_clear(psc));
  mid_prog_mem pm_u (.addr(pm_addr), .word(pm_word));
  // clock, and pulse counters
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (wdt === 1'b1) wdt_n++;
    if (psc === 1'b1) psc_n++;
  end
  // ==============================
  // verdict
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // ==============================
  // bus cycles, each held until its ready edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 40) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n == 40) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  // ==============================
  // load operands, execute one word, time it, read results back
  task automatic run_op(input logic [4:0] i, input logic [7:0] a, f, input logic [4:0] s,
                        input logic [7:0] ea, ef, input logic [4:0] es, input int ec);
    int c;
    pm_addr = i;
    wr(8'h04, {24'h0, a}, r);
    wr(8'h08, {24'h0, f}, r);
    wr(8'h0C, {27'h0, s}, r);
    wr(8'h00, {18'h0, pm_word}, r);
    chk({30'h0, r}, 32'h0, "instr response");
    c = 1;
    while (c < 20) begin
      @(posedge aclk);
      if (busy !== 1'b1) break;
      c++;
    end
    chk(c, ec, "busy clocks");
    if (c == 20) report_and_stop();
    rd(8'h04, d, r);
    chk(d[7:0], ea, "accumulator");
    rd(8'h08, d, r);
    chk(d[7:0], ef, "file value");
    rd(8'h0C, d, r);
    chk(d[4:0], es, "status");
  endtask
  // ==============================
  // main sequence
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; pins = 8'h00; pm_addr = 5'h00;
    mismatches = 0; cmp_count = 0; wdt_n = 0; psc_n = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    pins <= 8'hC3;
    run_op(5'h00, 8'h0F, 8'hF0, 5'h01, 8'h0F, 8'hFF, 5'h19, 4);
    run_op(5'h01, 8'h5A, 8'h5A, 5'h00, 8'h00, 8'h5A, 5'h1C, 4);
    run_op(5'h02, 8'h00, 8'h80, 5'h00, 8'h00, 8'h00, 5'h19, 4);
    run_op(5'h03, 8'h00, 8'h01, 5'h05, 8'h00, 8'h80, 5'h1D, 4);
    run_op(5'h04, 8'h00, 8'h01, 5'h00, 8'h00, 8'h00, 5'h18, 8);
    run_op(5'h05, 8'h00, 8'h10, 5'h04, 8'h11, 8'h10, 5'h1C, 4);
    run_op(5'h06, 8'h00, 8'h7F, 5'h00, 8'h00, 8'h7F, 5'h18, 8);
    run_op(5'h07, 8'h00, 8'h01, 5'h00, 8'h00, 8'h01, 5'h18, 8);
    run_op(5'h08, 8'hF0, 8'h00, 5'h00, 8'hFF, 8'h00, 5'h18, 4);
    run_op(5'h09, 8'hFF, 8'h00, 5'h00, 8'h00, 8'h00, 5'h1C, 4);
    run_op(5'h0A, 8'h03, 8'h00, 5'h00, 8'h02, 8'h00, 5'h1B, 4);
    run_op(5'h0B, 8'h00, 8'h00, 5'h07, 8'h3C, 8'h00, 5'h1F, 8);
    run_op(5'h0C, 8'h00, 8'h00, 5'h07, 8'h00, 8'h00, 5'h1F, 8);
    run_op(5'h0D, 8'h00, 8'h00, 5'h00, 8'h00, 8'h00, 5'h18, 8);
    run_op(5'h0E, 8'h00, 8'h00, 5'h00, 8'h00, 8'h00, 5'h18, 4);
    chk(wdt_n, 1, "watchdog pulses");
    run_op(5'h0F, 8'h00, 8'h00, 5'h00, 8'h00, 8'hC3, 5'h18, 4);
    run_op(5'h10, 8'h00, 8'h00, 5'h00, 8'h00, 8'h00, 5'h18, 8);
    rd(8'h1C, d, r);
    chk(d[10:0], 11'h7FF, "jump target");
    wr(8'h10, 32'h1, r);
    run_op(5'h11, 8'h01, 8'h00, 5'h00, 8'h01, 8'h01, 5'h18, 4);
    chk(psc_n, 1, "prescaler pulses");
    run_op(5'h12, 8'h00, 8'h00, 5'h00, 8'h00, 8'h00, 5'h08, 4);
    chk(standby, 1'b1, "standby entered");
    wr(8'h00, 32'h0, r);
    chk(r, 2'h2, "instr refused in standby");
    wr(8'h10, 32'h2, r);
    chk(standby, 1'b0, "standby left");
    rd(8'h40, d, r);
    chk(r, 2'h2, "unmapped read");
    run_op(5'h0E, 8'h00, 8'h00, 5'h00, 8'h00, 8'h00, 5'h18, 4);
    chk(wdt_n, 2, "watchdog pulses after standby");
    report_and_stop();
  end
endmodule
